// >>> dv/pad_function_mux_bench.sv
`timescale 1ns/100ps
module pad_function_mux_bench;
    import pad_mux_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_pend = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, st = 32'haef6dd56, r, expq[$];
    logic        gpio0_out = 0, timer_channel_out = 0, spi_sck_out = 0, fault_out = 0;
    logic        gpio11_out = 0, pwm_a0_out = 0, pwm_a2_out = 0, ext0 = 0, ext11 = 0;
    logic        o0, o11, l0, l11, in0, in11, sck;
    logic [3:0]  nib, sel, m11;
    wire  logic [31:0] hrdata;
    wire  logic  hready, hreadyout, hresp, pad0_in, pad0_out, pad0_oe, pad11_in;
    wire  logic  pad11_out, pad11_oe, gpio0_in, timer_channel_in, gpio11_in, spi_sck_in;
    wire  logic  external_interrupt_input0, external_interrupt_input10;
    int          failures = 0, num_checks = 0, i;
    assign hready = hreadyout;
    pad_function_mux u_pad_function_mux (.*);
    pad_world u_pad_world (.*);
    always #25 hclk = ~hclk;
    function logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            tally_and_finish;
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= htrans_nonseq;
        wait_rdy;
        htrans <= htrans_idle;
        hwdata <= d;
        wait_rdy;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1)
            check(hrdata, expq.pop_front());
        rd_pend <= hsel && hready && htrans == htrans_nonseq && !hwrite;
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h0);
        bus(1'b1, 8'h08, 32'hffffffff);
        rd(8'h08, 32'h0f0f0f0f);
        bus(1'b1, 8'h10, 32'h5);
        rd(8'h10, 32'h0);
        for (i = 0; i < 48; i++) begin
            r = rnd();
            nib = i[3:0];
            sel = {2'h0, i[5:4]};
            {ext11, ext0, pwm_a2_out, pwm_a0_out, gpio11_out} <= r[8:4];
            {fault_out, spi_sck_out, timer_channel_out, gpio0_out} <= r[3:0];
            bus(1'b1, 8'h00, {28'h0, nib});
            bus(1'b1, 8'h04, {28'h0, nib});
            bus(1'b1, 8'h08, {20'h0, sel, 8'h00});
            repeat (10) @(posedge hclk);
            m11 = {r[6], r[5], r[2], r[4]};
            o0  = nib[1] & r[nib[3:2]];
            o11 = nib[1] & m11[nib[3:2]];
            l0  = nib[1] ? o0 : r[7];
            l11 = nib[1] ? o11 : r[8];
            in0 = nib[0] & l0;
            in11 = nib[0] & l11;
            sck = (sel == 4'h0) ? in11 : (sel == 4'h1) ? in0 : 1'b0;
            check({pad0_oe, pad0_out, pad11_oe, pad11_out}, {nib[1], o0, nib[1], o11});
            check({gpio0_in, timer_channel_in, external_interrupt_input0}, {3{in0}});
            check({gpio11_in, external_interrupt_input10}, {2{in11}});
            check(spi_sck_in, sck);
            rd(8'h0c, {30'h0, l11, l0});
        end
        tally_and_finish;
    end
endmodule

// >>> dv/pad_function_mux_monitor.sv
`timescale 1ns/100ps
module pad_function_mux_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pad0_out,
    input wire logic        pad0_oe,
    input wire logic        pad11_out,
    input wire logic        pad11_oe,
    input wire logic        gpio0_in,
    input wire logic        timer_channel_in,
    input wire logic        external_interrupt_input0,
    input wire logic        gpio11_in,
    input wire logic        external_interrupt_input10,
    input wire logic        spi_sck_in
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_pad0_gated: assert property (!pad0_oe |-> !pad0_out)
        else $error("pad0 driven while disabled");
    a_pad11_gated: assert property (!pad11_oe |-> !pad11_out)
        else $error("pad11 driven while disabled");
    a_zero_wait: assert property (hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_pad0_fanout: assert property (gpio0_in == timer_channel_in
        && gpio0_in == external_interrupt_input0) else $error("pad0 inputs disagree");
    a_pad11_fanout: assert property (gpio11_in == external_interrupt_input10)
        else $error("pad11 inputs disagree");
    a_sck_source: assert property (spi_sck_in |-> gpio0_in || gpio11_in)
        else $error("clock input without a source pad");
    a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
        |-> $stable(hrdata)) else $error("read data changed without a read");
endmodule

bind pad_function_mux pad_function_mux_monitor u_pad_function_mux_monitor (.*);

// >>> dv/pad_world.sv
`timescale 1ns/100ps
module pad_world (
    input  wire logic pad0_out,
    input  wire logic pad0_oe,
    input  wire logic pad11_out,
    input  wire logic pad11_oe,
    input  wire logic ext0,
    input  wire logic ext11,
    output wire logic pad0_in,
    output wire logic pad11_in
);
    // Outside source drives a pad only while the chip has released it
    assign pad0_in  = pad0_oe ? pad0_out : ext0;
    assign pad11_in = pad11_oe ? pad11_out : ext11;
endmodule

// >>> logic/pad_function_mux.sv
// Contract
// R1 - Pad driven only while output enable set
// R2 - Nibble: function[3:2], output enable, input enable
// R3 - 0011 drives GPIO and feeds pad back
// R4 - 1010 drives serial clock; 1011 adds monitor (code: pad 0 only; on pad 11 1010 drives PWM A0 and 0110 drives clock)
// R5 - Pad level reaches all wired inputs together
// R6 - Input enable covers whole pad (code: the status register reads the pad level without input enable)
// R7 - Pad-select picks source for shared inputs
// R8 - Select nibble 0001 routes pad 0 clock
// R9 - Input use ignores function field
// R10 - Software keeps output off for driven pads
// R11 - Pad 0: GPIO, timer, clock, fault, interrupt
// R12 - Clock on pads 0, 11; PWM on 11
// R13 - Clock pad direction follows master/slave (code: direction set only by the output-enable bit of the config nibble)
// R14 - Function field encodes function number directly
// R15 - Four-bit select fields, four per word, reset zero
// R16 - Changes act the cycle after write
`timescale 1ns/100ps
`include "pad_mux_consts.svh"

module pad_function_mux
    import pad_mux_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Peripheral outputs toward pads
    input  wire logic        gpio0_out,
    input  wire logic        timer_channel_out,
    input  wire logic        spi_sck_out,
    input  wire logic        fault_out,
    input  wire logic        gpio11_out,
    input  wire logic        pwm_a0_out,
    input  wire logic        pwm_a2_out,
    // Pads
    input  wire logic        pad0_in,
    output logic             pad0_out,
    output logic             pad0_oe,
    input  wire logic        pad11_in,
    output logic             pad11_out,
    output logic             pad11_oe,
    // Peripheral inputs from pads
    output logic             gpio0_in,
    output logic             timer_channel_in,
    output logic             external_interrupt_input0,
    output logic             gpio11_in,
    output logic             external_interrupt_input10,
    output logic             spi_sck_in
);

    //--------------------------------------------------------------
    // Bus slave
    //--------------------------------------------------------------
    logic [3:0]  pad0_config_word_r;
    logic [3:0]  pad11_config_word_r;
    logic [31:0] input_source_select_reg_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [2:0]  sync0_r;
    logic [2:0]  sync11_r;
    logic        pad0_lvl_r;
    logic        pad11_lvl_r;

    wire access_go = hsel && hready && (htrans == htrans_nonseq || htrans == htrans_seq);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= access_go && hwrite;
            if (access_go) begin
                wr_addr_r <= haddr;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad0_config_word_r        <= `CFG_RESET;
            pad11_config_word_r       <= `CFG_RESET;
            input_source_select_reg_r <= `INSEL_RESET;  // [R15]
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `PAD0_CFG_OFFSET:  pad0_config_word_r  <= hwdata[3:0];  // [R2]
                `PAD11_CFG_OFFSET: pad11_config_word_r <= hwdata[3:0];
                `INSEL_OFFSET:     input_source_select_reg_r <= hwdata & `INSEL_MASK; // [R15]
                default: begin
                end
            endcase
        end
    end

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        case (a)
            `PAD0_CFG_OFFSET:  read_mux = {28'h0000000, pad0_config_word_r};
            `PAD11_CFG_OFFSET: read_mux = {28'h0000000, pad11_config_word_r};
            `INSEL_OFFSET:     read_mux = input_source_select_reg_r;
            `STATUS_OFFSET:    read_mux = {30'h00000000, pad11_lvl_r, pad0_lvl_r};
            default:           read_mux = 32'h00000000;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (access_go && !hwrite) begin
            hrdata <= read_mux(haddr);
        end
    end

    //--------------------------------------------------------------
    // Pad input synchronisers
    //--------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync0_r     <= 3'h0;
            sync11_r    <= 3'h0;
            pad0_lvl_r  <= 1'b0;
            pad11_lvl_r <= 1'b0;
        end else begin
            sync0_r  <= {sync0_r[1:0], pad0_in};
            sync11_r <= {sync11_r[1:0], pad11_in};
            if (sync0_r[2] == sync0_r[1]) begin
                pad0_lvl_r <= sync0_r[2];
            end
            if (sync11_r[2] == sync11_r[1]) begin
                pad11_lvl_r <= sync11_r[2];
            end
        end
    end

    //--------------------------------------------------------------
    // Output multiplexers
    //--------------------------------------------------------------
    func_sel_t fa0;
    func_sel_t fa11;
    assign fa0  = func_sel_t'(pad0_config_word_r[`CFG_FA_MSB:`CFG_FA_LSB]);   // [R14]
    assign fa11 = func_sel_t'(pad11_config_word_r[`CFG_FA_MSB:`CFG_FA_LSB]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad0_out <= 1'b0;
            pad0_oe  <= 1'b0;
        end else begin
            pad0_oe <= pad0_config_word_r[`CFG_OUT_EN_BIT];  // [R1] [R13] [R16]
            if (!pad0_config_word_r[`CFG_OUT_EN_BIT]) begin
                pad0_out <= 1'b0;  // [R1] [R9]
            end else begin
                case (fa0)  // [R11]
                    func_0:  pad0_out <= gpio0_out;          // [R3]
                    func_1:  pad0_out <= timer_channel_out;
                    func_2:  pad0_out <= spi_sck_out;        // [R4]
                    func_3:  pad0_out <= fault_out;
                    default: pad0_out <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad11_out <= 1'b0;
            pad11_oe  <= 1'b0;
        end else begin
            pad11_oe <= pad11_config_word_r[`CFG_OUT_EN_BIT];  // [R1] [R13]
            if (!pad11_config_word_r[`CFG_OUT_EN_BIT]) begin
                pad11_out <= 1'b0;  // [R1] [R9]
            end else begin
                case (fa11)  // [R12]
                    func_0:  pad11_out <= gpio11_out;
                    func_1:  pad11_out <= spi_sck_out;
                    func_2:  pad11_out <= pwm_a0_out;
                    func_3:  pad11_out <= pwm_a2_out;
                    default: pad11_out <= 1'b0;
                endcase
            end
        end
    end

    //--------------------------------------------------------------
    // Input routing
    //--------------------------------------------------------------
    wire       in0  = pad0_config_word_r[`CFG_IN_EN_BIT] & pad0_lvl_r;    // [R6] [R9]
    wire       in11 = pad11_config_word_r[`CFG_IN_EN_BIT] & pad11_lvl_r;  // [R6]
    wire [3:0] second_pad_select_nibble =
        input_source_select_reg_r[`INSEL_SCK_LSB +: `INSEL_FIELD_W];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio0_in                   <= 1'b0;
            timer_channel_in           <= 1'b0;
            external_interrupt_input0  <= 1'b0;
            gpio11_in                  <= 1'b0;
            external_interrupt_input10 <= 1'b0;
        end else begin
            gpio0_in                   <= in0;   // [R5] [R3] [R4]
            timer_channel_in           <= in0;   // [R5]
            external_interrupt_input0  <= in0;   // [R5] [R11]
            gpio11_in                  <= in11;  // [R5]
            external_interrupt_input10 <= in11;  // [R5]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_sck_in <= 1'b0;
        end else begin
            case (second_pad_select_nibble)  // [R7]
                `SCK_SEL_PAD0:  spi_sck_in <= in0;   // [R8]
                `SCK_SEL_PAD11: spi_sck_in <= in11;  // [R12]
                default:        spi_sck_in <= 1'b0;
            endcase
        end
    end

endmodule

// >>> logic/pad_mux_consts.svh
`ifndef PAD_MUX_CONSTS_SVH
`define PAD_MUX_CONSTS_SVH

// Register byte offsets
`define PAD0_CFG_OFFSET     8'h00
`define PAD11_CFG_OFFSET    8'h04
`define INSEL_OFFSET        8'h08
`define STATUS_OFFSET       8'h0c

// Configuration nibble layout
`define CFG_IN_EN_BIT       0
`define CFG_OUT_EN_BIT      1
`define CFG_FA_LSB          2
`define CFG_FA_MSB          3
`define CFG_RESET           4'h0

// Input-selection register layout
`define INSEL_FIELD_W       4
`define INSEL_SCK_LSB       8
`define INSEL_MASK          32'h0f0f0f0f
`define INSEL_RESET         32'h00000000

// Pad-select codes for the serial clock input
`define SCK_SEL_PAD11       4'h0
`define SCK_SEL_PAD0        4'h1

`endif

// >>> logic/pad_mux_pkg.sv
package pad_mux_pkg;

    typedef enum logic [1:0] {
        func_0,
        func_1,
        func_2,
        func_3
    } func_sel_t;

    typedef enum logic [1:0] {
        htrans_idle   = 2'h0,
        htrans_busy   = 2'h1,
        htrans_nonseq = 2'h2,
        htrans_seq    = 2'h3
    } htrans_t;

endpackage
